// ---- include/hism_pkg.sv ----
// ==========================================================================
// host interface select constants
package hism_pkg;

   // protocol select pin levels
   localparam logic PROTO_SPI = 1'b0;
   localparam logic PROTO_I2C = 1'b1;

   // fixed upper part of the seven-bit slave address
   localparam logic [4:0] I2C_ADDR_UPPER = 5'h04;
   localparam int I2C_ADDR_W = 7;

   // register holding the three-wire enable
   localparam logic [7:0] THREE_WIRE_REG_ADDR = 8'h4b;
   localparam int THREE_WIRE_BIT = 0;
   localparam logic THREE_WIRE_RESET = 1'b0;

   // reset values of the pin-facing flops
   localparam logic PIN_BIT_RESET = 1'b0;
   localparam logic [1:0] SYNC_RESET = 2'h0;

endpackage : hism_pkg

// ---- hw/hism_mux.sv ----
// Function
// [R1] device is only a slave, speaking SPI or I2C, never both at once
// [R2] protocol select pin low picks SPI, high picks I2C
// [R3] SPI defaults to four-wire with separate data in and data out pins
// [R4] software may switch SPI to three-wire with one shared data pin
// [R5] serial-out pin is SPI data out, or I2C address bit 0 input
// [R6] serial-in pin is SPI data in, three-wire data, or I2C data line
// [R7] chip-select pin is SPI select, or I2C address bit 1 input
// [R8] serial clock pin clocks SPI or I2C as selected
// [R9] three-wire enable write accepted only once power control bit is set
// [R10] upper five slave address bits are fixed, low two come from pins
// [R11] host keeps select and address pins stable while running
`timescale 1ns/100ps
`default_nettype none

module hism_mux (
   // core clock, reset, enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // serial clock pin, clock of the link domain
   input wire logic sck_i,
   // static select pins
   input wire logic protocol_select_pin_i,
   input wire logic chip_select_pin_i,
   // serial-out pin, three signals
   input wire logic serial_out_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_o,
   // serial-in pin, three signals
   input wire logic serial_in_pin_i,
   output logic serial_in_pin_o,
   output logic serial_in_pin_oe_o,
   // register write from the protocol engine, core domain
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic power_ctrl_i,
   // transmit request from the protocol engine, link domain
   input wire logic tx_bit_i,
   input wire logic tx_en_i,
   input wire logic sda_low_i,
   // mode and address to the protocol engine, core domain
   output logic i2c_mode_o,
   output logic spi_mode_o,
   output logic three_wire_o,
   output logic spi_select_o,
   output logic [6:0] i2c_addr_o,
   // received bit to the protocol engine, link domain
   output logic rx_bit_o,
   output logic link_i2c_o,
   output logic link_three_wire_o
);

   // ==========================================================================
   // core reset synchroniser
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // release reset through two flops
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= hism_pkg::SYNC_RESET;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ==========================================================================
   // pin synchronisers, core domain
   logic [1:0] ps_sync_reg;
   logic [1:0] ps_sync_next;
   logic [1:0] cs_sync_reg;
   logic [1:0] cs_sync_next;
   logic [1:0] so_sync_reg;
   logic [1:0] so_sync_next;

   // shift each pin level through two flops
   always_comb begin
      ps_sync_next = {ps_sync_reg[0], protocol_select_pin_i};
      cs_sync_next = {cs_sync_reg[0], chip_select_pin_i};
      so_sync_next = {so_sync_reg[0], serial_out_pin_i};
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ps_sync_reg <= hism_pkg::SYNC_RESET;
         cs_sync_reg <= hism_pkg::SYNC_RESET;
         so_sync_reg <= hism_pkg::SYNC_RESET;
      end else if (ce_i) begin
         ps_sync_reg <= ps_sync_next;
         cs_sync_reg <= cs_sync_next;
         so_sync_reg <= so_sync_next;
      end
   end

   // ==========================================================================
   // mode, three-wire enable and slave address, core domain
   logic i2c_mode_reg;
   logic i2c_mode_next;
   logic three_wire_reg;
   logic three_wire_next;
   logic spi_select_reg;
   logic spi_select_next;
   logic [6:0] i2c_addr_reg;
   logic [6:0] i2c_addr_next;

   // decode pins and the software write
   always_comb begin
      // exactly one protocol follows the select level
      i2c_mode_next = (ps_sync_reg[1] == hism_pkg::PROTO_I2C); // R1 R2
      three_wire_next = three_wire_reg; // R3
      if (reg_wr_i && power_ctrl_i && (reg_addr_i == hism_pkg::THREE_WIRE_REG_ADDR)) begin
         three_wire_next = reg_wdata_i[hism_pkg::THREE_WIRE_BIT]; // R4 R9
      end
      // chip select is active low in SPI mode only
      spi_select_next = !i2c_mode_next && !cs_sync_reg[1]; // R7
      // address low bits follow chip-select and serial-out levels
      i2c_addr_next = {hism_pkg::I2C_ADDR_UPPER, cs_sync_reg[1], so_sync_reg[1]}; // R5 R7 R10
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         i2c_mode_reg <= hism_pkg::PROTO_SPI;
         three_wire_reg <= hism_pkg::THREE_WIRE_RESET;
         spi_select_reg <= 1'b0;
         i2c_addr_reg <= {hism_pkg::I2C_ADDR_UPPER, 2'h0};
      end else if (ce_i) begin
         i2c_mode_reg <= i2c_mode_next;
         three_wire_reg <= three_wire_next;
         spi_select_reg <= spi_select_next;
         i2c_addr_reg <= i2c_addr_next;
      end
   end

   // core-side results
   assign i2c_mode_o = i2c_mode_reg;
   assign spi_mode_o = !i2c_mode_reg;
   assign three_wire_o = three_wire_reg;
   assign spi_select_o = spi_select_reg;
   assign i2c_addr_o = i2c_addr_reg;

   // ==========================================================================
   // mode levels into the link domain
   logic [1:0] lk_i2c_sync_reg;
   logic [1:0] lk_i2c_sync_next;
   logic [1:0] lk_3w_sync_reg;
   logic [1:0] lk_3w_sync_next;

   // two flops on the serial clock for each level
   always_comb begin
      lk_i2c_sync_next = {lk_i2c_sync_reg[0], i2c_mode_reg};
      lk_3w_sync_next = {lk_3w_sync_reg[0], three_wire_reg};
   end

   // reset acts without the serial clock, which may stand still
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         lk_i2c_sync_reg <= hism_pkg::SYNC_RESET;
         lk_3w_sync_reg <= hism_pkg::SYNC_RESET;
      end else begin
         lk_i2c_sync_reg <= lk_i2c_sync_next;
         lk_3w_sync_reg <= lk_3w_sync_next;
      end
   end

   assign link_i2c_o = lk_i2c_sync_reg[1];
   assign link_three_wire_o = lk_3w_sync_reg[1];

   // ==========================================================================
   // receive sampling on the rising serial clock
   logic rx_bit_reg;
   logic rx_bit_next;

   // serial-in pin carries data in every mode
   always_comb begin
      rx_bit_next = serial_in_pin_i; // R6 R8
   end

   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_bit_reg <= hism_pkg::PIN_BIT_RESET;
      end else begin
         rx_bit_reg <= rx_bit_next;
      end
   end

   assign rx_bit_o = rx_bit_reg;

   // ==========================================================================
   // transmit launch on the falling serial clock
   logic tx_bit_reg;
   logic tx_bit_next;
   logic tx_en_reg;
   logic tx_en_next;
   logic sda_low_reg;
   logic sda_low_next;

   // capture engine requests per protocol
   always_comb begin
      tx_bit_next = tx_bit_i;
      tx_en_next = tx_en_i && !lk_i2c_sync_reg[1]; // R1
      sda_low_next = sda_low_i && lk_i2c_sync_reg[1]; // R1
   end

   always_ff @(negedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_bit_reg <= hism_pkg::PIN_BIT_RESET;
         tx_en_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else begin
         tx_bit_reg <= tx_bit_next;
         tx_en_reg <= tx_en_next;
         sda_low_reg <= sda_low_next;
      end
   end

   // ==========================================================================
   // pin drivers
   logic spi_4w;
   logic spi_3w;

   assign spi_4w = !lk_i2c_sync_reg[1] && !lk_3w_sync_reg[1];
   assign spi_3w = !lk_i2c_sync_reg[1] && lk_3w_sync_reg[1];

   // serial-out drives only in four-wire SPI, input in I2C
   always_comb begin
      serial_out_pin_o = tx_bit_reg; // R5
      serial_out_pin_oe_o = spi_4w && tx_en_reg && !chip_select_pin_i; // R3 R5
   end

   // serial-in: three-wire data out, or open-drain low for I2C
   always_comb begin
      serial_in_pin_o = 1'b0;
      serial_in_pin_oe_o = 1'b0;
      if (spi_3w) begin
         serial_in_pin_o = tx_bit_reg; // R4 R6
         serial_in_pin_oe_o = tx_en_reg && !chip_select_pin_i; // R4 R6
      end else if (lk_i2c_sync_reg[1]) begin
         serial_in_pin_oe_o = sda_low_reg; // R6
      end
   end

endmodule : hism_mux

`default_nettype wire

// ---- bench/hism_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// host controller: clock frames and pin levels
module hism_host_model (
   input wire logic protocol_select_pin_i, strap_i, host_bit_i, host_drv_i,
   input wire logic sdo_i, sdo_oe_i, sdi_i, sdi_oe_i,
   output var logic sck_o,
   output logic sdo_pin_o, sdi_pin_o
);
   logic last_reg = 1'b0;
   initial sck_o = 1'b1;
   // released serial-out shows the board strap level
   assign sdo_pin_o = sdo_oe_i ? sdo_i : strap_i;
   // pulled up in i2c, otherwise flips when nobody drives
   assign sdi_pin_o = sdi_oe_i ? sdi_i : host_drv_i ? host_bit_i :
      protocol_select_pin_i ? 1'b1 : ~last_reg;
   always @(posedge sck_o) last_reg <= sdi_pin_o;
   // frame of n clocks, idle high and still between frames
   task automatic frame(input int n, input real half);
      repeat (n) begin
         #half sck_o = 1'b0;
         #half sck_o = 1'b1;
      end
   endtask : frame
endmodule : hism_host_model
`default_nettype wire

// ---- bench/hism_mux_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// port checker
module hism_mux_monitor (
   input wire logic clk_i, resetn_i, protocol_select_pin_i, chip_select_pin_i,
   input wire logic serial_out_pin_i, reg_wr_i, power_ctrl_i, serial_out_pin_oe_o,
   input wire logic serial_in_pin_o, serial_in_pin_oe_o, i2c_mode_o, three_wire_o,
   input wire logic spi_select_o, link_i2c_o, link_three_wire_o,
   input wire logic [7:0] reg_addr_i, reg_wdata_i,
   input wire logic [6:0] i2c_addr_o
);
   logic [2:0] up_reg, up_next;
   logic wr;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // saturating count since reset
   always_comb up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i) up_reg <= 3'h0;
      else up_reg <= up_next;
   assign wr = reg_wr_i && reg_addr_i == 8'h4b && power_ctrl_i;
   // select and strap pins quiet for four cycles
   sequence calm;
      (up_reg == 3'h7 && $stable({protocol_select_pin_i, chip_select_pin_i,
         serial_out_pin_i}))[*4];
   endsequence
   chk_mode_pin: assert property (calm |-> i2c_mode_o == protocol_select_pin_i)
      else $error("mode differs from select pin");
   chk_addr_pin: assert property (calm |->
      i2c_addr_o == {5'h04, chip_select_pin_i, serial_out_pin_i}) else $error("bad address");
   chk_spi_sel: assert property (calm |->
      spi_select_o == (!protocol_select_pin_i && !chip_select_pin_i)) else $error("bad select");
   chk_wire_take: assert property (wr |=> three_wire_o == $past(reg_wdata_i[0]))
      else $error("three-wire write lost");
   chk_wire_keep: assert property (!wr |=> $stable(three_wire_o))
      else $error("three-wire changed without write");
   chk_sdo_quiet: assert property (chip_select_pin_i || link_i2c_o || link_three_wire_o
      |-> !serial_out_pin_oe_o) else $error("serial-out driven");
   chk_sdi_quiet: assert property (!link_i2c_o && !link_three_wire_o
      |-> !serial_in_pin_oe_o) else $error("serial-in driven in four-wire");
   chk_sda_low: assert property (link_i2c_o && serial_in_pin_oe_o |-> !serial_in_pin_o)
      else $error("data line driven high");
endmodule : hism_mux_monitor
bind hism_mux hism_mux_monitor chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .protocol_select_pin_i(protocol_select_pin_i), .chip_select_pin_i(chip_select_pin_i),
   .serial_out_pin_i(serial_out_pin_i), .reg_wr_i(reg_wr_i), .power_ctrl_i(power_ctrl_i),
   .serial_out_pin_oe_o(serial_out_pin_oe_o), .serial_in_pin_o(serial_in_pin_o),
   .serial_in_pin_oe_o(serial_in_pin_oe_o), .i2c_mode_o(i2c_mode_o),
   .three_wire_o(three_wire_o), .spi_select_o(spi_select_o), .link_i2c_o(link_i2c_o),
   .link_three_wire_o(link_three_wire_o), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .i2c_addr_o(i2c_addr_o));
`default_nettype wire

// ---- bench/hism_mux_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// bench for the interface select mux
module hism_mux_tb;
   logic clk = 1'b0, rstn = 1'b0, ps = 1'b0, cs = 1'b0, strap = 1'b0, wr = 1'b0, pwr = 1'b0;
   logic tx_bit = 1'b0, tx_en = 1'b0, sda_low = 1'b0, hb = 1'b0, hd = 1'b0, w3 = 1'b0;
   logic exp_rx, t, e, s;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic [31:0] seed = 32'h53;
   wire sck, sdo_pin, sdi_pin, serial_out_pin, sdo_oe, serial_in_pin, sdi_oe, i2c, spi, thr, sel, rxb, li2c, l3w;
   wire [6:0] i2c_addr;
   int mismatches = 0, num_checks = 0;
   always #50 clk = ~clk;
   hism_mux uut (.clk_i(clk), .resetn_i(rstn), .ce_i(1'b1), .sck_i(sck),
      .protocol_select_pin_i(ps), .chip_select_pin_i(cs), .serial_out_pin_i(sdo_pin),
      .serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(sdo_oe), .serial_in_pin_i(sdi_pin),
      .serial_in_pin_o(serial_in_pin), .serial_in_pin_oe_o(sdi_oe), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .power_ctrl_i(pwr), .tx_bit_i(tx_bit), .tx_en_i(tx_en),
      .sda_low_i(sda_low), .i2c_mode_o(i2c), .spi_mode_o(spi), .three_wire_o(thr),
      .spi_select_o(sel), .i2c_addr_o(i2c_addr), .rx_bit_o(rxb), .link_i2c_o(li2c),
      .link_three_wire_o(l3w));
   hism_host_model host (.protocol_select_pin_i(ps), .strap_i(strap), .host_bit_i(hb),
      .host_drv_i(hd), .sdo_i(serial_out_pin), .sdo_oe_i(sdo_oe), .sdi_i(serial_in_pin), .sdi_oe_i(sdi_oe),
      .sck_o(sck), .sdo_pin_o(sdo_pin), .sdi_pin_o(sdi_pin));
   function automatic logic rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[0];
   endfunction : rnd
   task automatic cmp(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // set select and strap pins, let them settle, check mode and address
   task automatic pins(input logic p, c, d);
      @(posedge clk);
      ps <= p;
      cs <= c;
      strap <= d;
      repeat (5) @(posedge clk);
      cmp(i2c, p);
      cmp(spi, !p);
      cmp(sel, !p && !c);
      cmp(i2c_addr, {1'b0, 5'h04, c, d});
   endtask : pins
   // register write with random upper data bits
   task automatic wreg(input logic [7:0] a, input logic p, b);
      void'(rnd());
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      pwr <= p;
      wdata <= {seed[7:1], b};
      if (a == 8'h4b && p) w3 = b;
      @(posedge clk);
      wr <= 1'b0;
      #1 cmp(thr, w3);
   endtask : wreg
   // idle preamble carries the mode across, then a driven frame
   // and one idle clock so the launch flops let go of the pins
   task automatic run(input logic te, sl, d, input int n, input real half);
      host.frame(3, half);
      cmp(li2c, ps);
      cmp(l3w, w3);
      tx_en <= te;
      sda_low <= sl;
      hd <= d;
      host.frame(n, half);
      tx_en <= 1'b0;
      sda_low <= 1'b0;
      host.frame(1, half);
   endtask : run
   // device drives after the falling edge
   always @(negedge sck) begin
      t = tx_bit;
      e = tx_en;
      s = sda_low;
      hb <= rnd();
      #5 cmp(sdo_oe, !ps && !cs && e && !w3);
      cmp(sdi_oe, ps ? s : !cs && e && w3);
      if (sdi_oe === 1'b1) cmp(serial_in_pin, ps ? 1'b0 : t);
      if (sdo_oe === 1'b1) cmp(serial_out_pin, t);
   end
   // host samples on the rising edge, its own data moves on the falling one
   always @(posedge sck) begin
      exp_rx = sdi_pin;
      tx_bit <= rnd();
      #5 if (rstn) cmp(rxb, exp_rx);
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      cmp(i2c_addr, 8'h10);
      cmp(thr, 1'b0);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) pins(i[2], i[1], i[0]);
      pins(1'b0, 1'b0, 1'b0);
      run(1'b1, 1'b0, 1'b1, 8, 62.5);
      pins(1'b0, 1'b1, 1'b0);
      run(1'b1, 1'b0, 1'b1, 6, 62.5);
      wreg(8'h4b, 1'b0, 1'b1);
      wreg(8'h4c, 1'b1, 1'b1);
      wreg(8'h4b, 1'b1, 1'b1);
      pins(1'b0, 1'b0, 1'b0);
      run(1'b1, 1'b0, 1'b0, 8, 62.5);
      pins(1'b1, 1'b1, 1'b1);
      run(1'b1, 1'b1, 1'b1, 8, 62.5);
      wreg(8'h4b, 1'b1, 1'b0);
      end_of_test();
   end
   // watchdog, far beyond the expected run length
   initial begin
      #3000000;
      mismatches++;
      end_of_test();
   end
endmodule : hism_mux_tb
`default_nettype wire
